// File: dv/lsfm_chk.sv
`timescale 1ns/100ps
`default_nettype none
// ****
// port checks for the fault manager
// ****
module lsfm_chk
   import lsfm_pkg::*;
#(parameter int CHANNELS = 4, parameter int RAMP_STEPS = 16) (
   // clock and pins
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic enable_in,
   input wire logic dim_pwm_in,
   input wire logic overvoltage_sense_in,
   input wire logic thermal_shutdown_in,
   input wire logic switch_cycle_start_in,
   input wire logic pwm_gate_in,
   // outputs
   input wire logic [CHANNELS-1:0] channel_enable_q,
   input wire logic [CHANNELS-1:0] selector_mask_q,
   input wire logic [7:0] min_sink_voltage_q,
   input wire logic gate_drive_out_q,
   input wire logic fault_flag_n_q,
   input wire logic fault_flag_n_oe_q,
   input wire logic [LSFM_RAMP_W-1:0] ramp_current_q
);
   // repeats of 4 cover the 2-flop sync plus output stage
   default clocking @(posedge sys_clk);
   endclocking
   default disable iff (rst);
   gate_ovp_a: assert property (overvoltage_sense_in [*4] |->
      !gate_drive_out_q) else $error("gate on during overvoltage");
   gate_idle_a: assert property (!pwm_gate_in [*4] |->
      !gate_drive_out_q) else $error("gate on without request");
   dim_off_a: assert property (!dim_pwm_in [*4] |->
      channel_enable_q == '0) else $error("sink on with dimming low");
   flag_drive_a: assert property (
      fault_flag_n_oe_q == fault_flag_n_q) else $error("flag enable wrong");
   hot_flag_a: assert property (
      (thermal_shutdown_in && enable_in) [*6] |-> !fault_flag_n_q)
      else $error("no flag in thermal shutdown");
   empty_min_a: assert property ((selector_mask_q == '0) [*2] |->
      min_sink_voltage_q == 8'hFF) else $error("min without channels");
   ramp_range_a: assert property (
      ramp_current_q < RAMP_STEPS) else $error("ramp past full scale");
   ramp_restart_a: assert property ($rose(switch_cycle_start_in) |->
      ##[1:4] ramp_current_q == '0) else $error("ramp did not restart");
endmodule // lsfm_chk
bind lsfm_fault_manager lsfm_chk #(.CHANNELS(CHANNELS),
   .RAMP_STEPS(RAMP_STEPS)) lsfm_chk_inst (.*);
`default_nettype wire

// File: dv/lsfm_host_model.sv
`timescale 1ns/100ps
`default_nettype none
// ****
// host: dimming source and flag pull-up
// ****
module lsfm_host_model (
   // clock and control
   input wire logic sys_clk,
   input wire logic dim_run,
   // pins
   input wire logic fault_flag_n_q,
   input wire logic fault_flag_n_oe_q,
   output logic dim_pwm_in,
   output logic flag_pin
);
   logic [5:0] phase = 6'h0;
   initial dim_pwm_in = 1'h0;
   // half duty, 64-cycle period so rises are sparse
   always @(posedge sys_clk) begin
      phase <= phase + 6'h1;
      dim_pwm_in <= dim_run && !phase[5];
   end
   // released line reads high through the pull-up
   assign flag_pin = fault_flag_n_oe_q ? 1'h1 : fault_flag_n_q;
endmodule // lsfm_host_model
`default_nettype wire

// File: dv/tb.sv
`timescale 1ns/100ps
`default_nettype none
// ****
// fault manager bench
// ****
module tb;
   import lsfm_pkg::*;
   logic sys_clk = 1'h0, rst = 1'h1, enable_in = 1'h0, dim_run = 1'h0;
   logic overvoltage_sense_in = 1'h0, softstart_done_in = 1'h0;
   logic short_disable_in = 1'h0, thermal_shutdown_in = 1'h0;
   logic switch_cycle_start_in = 1'h0, pwm_gate_in = 1'h0;
   logic probe = 1'h0, last = 1'h1, dim_pwm_in, flag_pin;
   logic fault_flag_n_q, fault_flag_n_oe_q, gate_drive_out_q;
   logic [3:0] channel_enable_q, selector_mask_q;
   logic [7:0] min_sink_voltage_q, emin;
   logic [5:0] ramp_current_q;
   logic [31:0] sink_voltage_in = 32'h0;
   lsfm_sense_s sense_in = '{4'h8, 4'h0, 4'h0};
   logic exp_q[$];
   int bad_count = 0, comparisons = 0, cyc = 0;
   always #4 sys_clk = ~sys_clk;
   lsfm_fault_manager lsfm_fault_manager_inst (.*);
   lsfm_host_model lsfm_host_model_inst (.*);
   task automatic test_done();
      if (bad_count == 0 && comparisons > 0 && exp_q.size() == 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task automatic check8(input logic [7:0] got, input logic [7:0] want);
      comparisons++;
      if (got !== want) begin
         bad_count++;
         $display("Error %0t: got %h want %h", $time, got, want);
      end
   endtask
   task automatic wait_n(input int n);
      repeat (n) @(posedge sys_clk);
   endtask
   task automatic probe_flag(input logic v);
      exp_q.push_back(v);
      probe <= 1'h1;
      wait_n(1);
      probe <= 1'h0;
   endtask
   // flag pin scoreboard: any edge or probe takes the oldest note
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      switch_cycle_start_in <= (cyc % 20 == 0);
      pwm_gate_in <= cyc[4];
      if (!rst && (flag_pin !== last || probe)) begin
         last = flag_pin;
         check8({7'h0, flag_pin}, {7'h0, exp_q.size() ? exp_q.pop_front() : 1'hX});
      end
      if (cyc == 5000) begin
         bad_count++;
         test_done();
      end
   end
   initial begin
      void'($urandom(32'hBDCC));
      wait_n(8);
      rst <= 1'h0;
      enable_in <= 1'h1;
      wait_n(10);
      softstart_done_in <= 1'h1;
      dim_run <= 1'h1;
      repeat (3) begin
         sink_voltage_in <= $urandom;
         // no shorts and nothing low: neither may move mask or minimum
         {short_disable_in, overvoltage_sense_in} <= 2'($urandom);
         wait_n(6);
         emin = 8'hFF;
         for (int i = 0; i < 3; i++) begin
            if (sink_voltage_in[i*8+:8] < emin) emin = sink_voltage_in[i*8+:8];
         end
         check8(min_sink_voltage_q, emin);
         check8({4'h0, selector_mask_q}, 8'h07);
      end
      short_disable_in <= 1'h0;
      overvoltage_sense_in <= 1'h0;
      exp_q.push_back(1'h0);
      exp_q.push_back(1'h1);
      thermal_shutdown_in <= 1'h1;
      wait_n(10);
      thermal_shutdown_in <= 1'h0;
      wait_n(10);
      @(negedge dim_pwm_in);
      sense_in.shorted <= 4'h2;
      wait_n(5);
      probe_flag(1'h1);
      exp_q.push_back(1'h0);
      @(posedge dim_pwm_in);
      wait_n(6);
      check8({4'h0, channel_enable_q}, 8'h05);
      sense_in.shorted <= 4'h0;
      wait_n(6);
      probe_flag(1'h0);
      exp_q.push_back(1'h1);
      @(posedge dim_pwm_in);
      wait_n(6);
      short_disable_in <= 1'h1;
      sense_in.shorted <= 4'h4;
      @(posedge dim_pwm_in);
      wait_n(6);
      probe_flag(1'h1);
      // low voltage on the grounded channel only
      sense_in <= '{4'h8, 4'h8, 4'h0};
      short_disable_in <= 1'h0;
      overvoltage_sense_in <= 1'h1;
      wait_n(8);
      probe_flag(1'h1);
      exp_q.push_back(1'h0);
      sense_in.below_low <= 4'h9;
      wait_n(8);
      check8({7'h0, selector_mask_q[0]}, 8'h00);
      overvoltage_sense_in <= 1'h0;
      sense_in.below_low <= 4'h0;
      wait_n(10);
      probe_flag(1'h0);
      exp_q.push_back(1'h1);
      enable_in <= 1'h0;
      // every output grounded: selector empties, minimum idles
      sense_in.tied_ground <= 4'hF;
      wait_n(6);
      enable_in <= 1'h1;
      wait_n(20);
      check8({4'h0, selector_mask_q}, 8'h00);
      check8(min_sink_voltage_q, 8'hFF);
      test_done();
   end
endmodule // tb
`default_nettype wire

// File: hw/lsfm_fault_manager.sv
// Operation
// RQ1 - unused channels dropped before soft-start
// RQ2 - grounded outputs mean unused, no fault
// RQ3 - after soft-start open strings leave selector
// RQ4 - feedback is lowest connected channel
// RQ5 - overvoltage stops gate drive low
// RQ6 - overvoltage drops channels below low threshold
// RQ7 - open-string overvoltage latches fault flag
// RQ8 - short check only at dimming rise
// RQ9 - short flag held until clean check
// RQ10 - threshold tied to regulator disables shorts
// RQ11 - slope ramp restarts each switching cycle
// RQ12 - short judged by comparator input
// RQ13 - latch cleared by power or enable
// RQ14 - dimming level gates all channels
// RQ15 - thermal fault flag, not latched
`timescale 1ns/100ps
`default_nettype none
module lsfm_fault_manager
   import lsfm_pkg::*;
#(
   parameter int CHANNELS = LSFM_CHANNELS,
   parameter int RAMP_STEPS = LSFM_RAMP_STEPS
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic enable_in,
   // analog status pins
   input wire logic dim_pwm_in,
   input wire logic overvoltage_sense_in,
   input wire logic softstart_done_in,
   input wire logic short_disable_in,
   input wire logic thermal_shutdown_in,
   input wire logic switch_cycle_start_in,
   input wire logic pwm_gate_in,
   input wire lsfm_sense_s sense_in,
   input wire logic [CHANNELS*8-1:0] sink_voltage_in,
   // outputs
   output logic [CHANNELS-1:0] channel_enable_q,
   output logic [CHANNELS-1:0] selector_mask_q,
   output logic [7:0] min_sink_voltage_q,
   output logic gate_drive_out_q,
   output logic fault_flag_n_q,
   output logic fault_flag_n_oe_q,
   output logic [LSFM_RAMP_W-1:0] ramp_current_q
);
   // struct fields are four wide, ramp counter six bits
   if (CHANNELS != LSFM_CHANNELS) begin : g_bad_channels
      $error("four channels only");
   end
   if (RAMP_STEPS < 2 || RAMP_STEPS > 63) begin : g_bad_ramp
      $error("bad ramp steps");
   end

   // ****************************************
   // input synchronisers
   // ****************************************
   localparam int SW = 8 + 3 * CHANNELS;
   logic [SW-1:0] s1_q, s2_q;
   logic en_sync, dim_s, ovp_s, ss_s, sdis_s, therm_s, cyc_s, gate_s;
   logic [CHANNELS-1:0] gnd_s, low_s, shrt_s;
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         s1_q <= '0;
         s2_q <= '0;
      end else begin
         s1_q <= {enable_in, dim_pwm_in, overvoltage_sense_in,
                  softstart_done_in, short_disable_in,
                  thermal_shutdown_in, switch_cycle_start_in, pwm_gate_in,
                  sense_in};
         s2_q <= s1_q;
      end
   end
   assign {en_sync, dim_s, ovp_s, ss_s, sdis_s, therm_s, cyc_s, gate_s,
           gnd_s, low_s, shrt_s} = s2_q;

   // enable low acts as a synchronous reset of all fault state
   logic clr;
   assign clr = !en_sync;

   // ****************************************
   // sequencer
   // ****************************************
   lsfm_state_e state_q;
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         state_q <= LSFM_IDLE;
      end else if (clr) begin
         state_q <= LSFM_IDLE;
      end else begin
         case (state_q)
            LSFM_IDLE: state_q <= LSFM_DETECT;
            // RQ1 detect before soft-start
            LSFM_DETECT: state_q <= LSFM_SOFTSTART;
            LSFM_SOFTSTART: if (ss_s || ovp_s) state_q <= LSFM_RUN;
            LSFM_RUN: state_q <= LSFM_RUN;
            default: state_q <= LSFM_IDLE;
         endcase
      end
   end

   // ****************************************
   // channel exclusion
   // ****************************************
   logic [CHANNELS-1:0] unused_q, open_q, short_q;
   logic dim_prev_q, dim_rise;
   assign dim_rise = dim_s && !dim_prev_q;
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) dim_prev_q <= 1'b0;
      else dim_prev_q <= dim_s;
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         unused_q <= LSFM_CH_RESET;
      end else if (clr) begin
         unused_q <= LSFM_CH_RESET;
      end else if (state_q == LSFM_DETECT) begin
         // RQ2 grounded means unused
         unused_q <= gnd_s;
      end
   end

   // opens are only judged in run, entered once soft-start is over or on overvoltage
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         open_q <= LSFM_CH_RESET;
      end else if (clr) begin
         open_q <= LSFM_CH_RESET;
      end else if (state_q == LSFM_RUN && ovp_s) begin
         // RQ3 RQ6 drop low channels
         open_q <= open_q | (low_s & ~unused_q);
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         short_q <= LSFM_CH_RESET;
      end else if (clr || sdis_s) begin
         // RQ10 detection off
         short_q <= LSFM_CH_RESET;
      end else if (dim_rise && state_q == LSFM_RUN) begin
         // RQ8 RQ12 sample at rise
         short_q <= shrt_s & ~unused_q & ~open_q;
      end
   end

   logic [CHANNELS-1:0] excluded;
   assign excluded = unused_q | open_q | short_q;

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         channel_enable_q <= LSFM_CH_RESET;
         selector_mask_q <= LSFM_CH_RESET;
      end else begin
         // RQ14 dimming gates all
         channel_enable_q <= (dim_s && state_q != LSFM_IDLE &&
                              state_q != LSFM_DETECT) ?
                             ~excluded : LSFM_CH_RESET;
         selector_mask_q <= ~excluded;
      end
   end

   // ****************************************
   // minimum selector
   // ****************************************
   logic [7:0] min_v;
   always_comb begin
      min_v = 8'hFF;
      for (int i = 0; i < CHANNELS; i++) begin
         // RQ4 lowest connected channel
         if (!excluded[i] && sink_voltage_in[i*8 +: 8] < min_v)
            min_v = sink_voltage_in[i*8 +: 8];
      end
   end
   // sink voltages are sampled words from the same-clock converter
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) min_sink_voltage_q <= 8'hFF;
      else min_sink_voltage_q <= min_v;
   end

   // ****************************************
   // gate drive and fault flag
   // ****************************************
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         gate_drive_out_q <= 1'b0;
      end else begin
         // RQ5 overvoltage holds low
         gate_drive_out_q <= gate_s && !ovp_s && !therm_s && !clr &&
                             state_q != LSFM_IDLE &&
                             state_q != LSFM_DETECT;
      end
   end

   logic open_latch_q;
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         open_latch_q <= 1'b0;
      end else if (clr) begin
         // RQ13 enable toggle clears
         open_latch_q <= 1'b0;
      end else if (state_q == LSFM_RUN && ovp_s &&
                   |(low_s & ~unused_q)) begin
         // RQ7 latch open fault
         open_latch_q <= 1'b1;
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         fault_flag_n_q <= LSFM_FLAG_OFF;
         fault_flag_n_oe_q <= 1'b1;
      end else begin
         // RQ9 RQ15 flag sources
         fault_flag_n_q <= !(open_latch_q || (|short_q) || therm_s);
         // open drain: enable low while pulling low
         fault_flag_n_oe_q <= !(open_latch_q || (|short_q) || therm_s);
      end
   end

   // ****************************************
   // slope ramp
   // ****************************************
   localparam logic [LSFM_RAMP_W-1:0] RAMP_TOP =
      LSFM_RAMP_W'(RAMP_STEPS - 1);
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         ramp_current_q <= '0;
      end else if (cyc_s) begin
         // RQ11 restart at cycle
         ramp_current_q <= '0;
      end else if (ramp_current_q < RAMP_TOP) begin
         ramp_current_q <= ramp_current_q + 1'b1;
      end
   end
endmodule // lsfm_fault_manager
`default_nettype wire

// File: hw/lsfm_pkg.sv
`default_nettype none
package lsfm_pkg;
   localparam int LSFM_CHANNELS = 4;
   // slope ramp full scale, in microamps
   localparam int LSFM_RAMP_FULL_UA = 50;
   localparam int LSFM_RAMP_STEPS = 16;
   localparam int LSFM_RAMP_W = 6;
   localparam logic [3:0] LSFM_CH_RESET = 4'h0;
   localparam logic LSFM_FLAG_OFF = 1'b1;

   typedef enum {
      LSFM_IDLE,
      LSFM_DETECT,
      LSFM_SOFTSTART,
      LSFM_RUN
   } lsfm_state_e;

   // per-channel analog comparator results
   typedef struct packed {
      logic [3:0] tied_ground;
      logic [3:0] below_low;
      logic [3:0] shorted;
   } lsfm_sense_s;
endpackage
`default_nettype wire
